// >>> shared/mpr_params.svh
// constants of the parity-protected cache: widths, vector, reset values
// assumes inclusion by the package, the design module and the testbench
`ifndef MPR_PARAMS_SVH
`define MPR_PARAMS_SVH
`define MPR_AW          21        // word address bits (22-bit byte space)
`define MPR_IW          4         // cache index bits
`define MPR_ERR_VECTOR  8'h4c     // error vector, octal 114
`define MPR_VEC_NONE    8'h00
`define MPR_ERR_CLEAR   5'h00
`endif

// >>> shared/mpr_pkg.sv
// types shared by the parity-protected cache and its surroundings
// assumes mpr_params.svh is on the include path
package mpr_pkg;
  `include "mpr_params.svh"

  typedef enum logic [1:0] {
    MPR_IDLE,
    MPR_MRD,
    MPR_MWR
  } mpr_state_e;

  // processor request, data carries odd parity per byte
  typedef struct packed {
    logic [`MPR_AW-1:0] addr;
    logic               we;
    logic [1:0]         be;
    logic [15:0]        wdata;
    logic [1:0]         wpar;
  } mpr_req_s;

  // sticky error sources seen by the logging routine
  typedef struct packed {
    logic cpu_data;
    logic cache_data;
    logic cache_tag;
    logic mem_data;
    logic mem_addr;
  } mpr_err_s;
endpackage

// >>> src/mpr_cache.sv
// parity-protected write-through cache between processor and two-word-block memory
// assumes bypass/force controls come from control registers on the same clock
`timescale 1ns/1ns
`include "mpr_params.svh"
module mpr_cache
  import mpr_pkg::*;
#(
  parameter int AW = `MPR_AW,
  parameter int IW = `MPR_IW
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_byp_lo,      // bypass lower cache half
  input  wire logic        i_byp_hi,      // bypass upper cache half
  input  wire logic        i_force_miss,
  input  wire logic        i_req,
  input  wire mpr_req_s    i_rq,
  output logic             o_ack,
  output logic [15:0]      o_rdata,
  output logic [1:0]       o_rpar,
  output logic             o_abort,
  output logic             o_trap,
  output logic [7:0]       o_vector,
  input  wire logic        i_instr_done,
  output mpr_err_s         o_err,
  input  wire logic        i_err_clr,
  output logic             o_mem_req,
  output logic [AW-2:0]    o_mem_addr,
  output logic             o_mem_we,
  output logic [3:0]       o_mem_be,
  output logic [31:0]      o_mem_wdata,
  output logic [3:0]       o_mem_wpar,
  output logic             o_mem_apar,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata,
  input  wire logic [3:0]  i_mem_rpar,
  input  wire logic        i_mem_aerr
);
  localparam int TW    = AW - 1 - IW;
  localparam int LINES = 1 << IW;
  // odd parity of one byte
  function automatic logic par8(input logic [7:0] b);
    return ~(^b);
  endfunction
  // two tag parity bits: lower and upper half of the tag
  function automatic logic [1:0] tpar(input logic [TW-1:0] t);
    return {~(^t[TW-1:TW/2]), ~(^t[TW/2-1:0])};
  endfunction
  // line usable unless its half is bypassed
  function automatic logic usable(input logic [IW-1:0] ix, input logic lo, input logic hi);
    return ix[IW-1] ? ~hi : ~lo;
  endfunction
  // storage in flip-flops
  logic [TW-1:0] tag_q  [LINES];
  logic [1:0]    tagp_q [LINES];
  logic [31:0]   dat_q  [LINES];
  logic [3:0]    datp_q [LINES];
  logic [LINES-1:0] val_q;
  mpr_state_e  st_q;
  mpr_req_s    rq_q;
  mpr_err_s    err_q;
  logic        trap_pend_q;
  logic        ack_q, abort_q, trap_q;
  logic [15:0] rdata_q;
  logic [1:0]  rpar_q;
  logic [7:0]  vec_q;
  logic        mreq_q, mwe_q, mapar_q;
  logic [AW-2:0] maddr_q;
  logic [3:0]  mbe_q, mwpar_q;
  logic [31:0] mwdata_q;
  // lookup on the incoming request
  logic [IW-1:0] ix;
  logic [TW-1:0] tg;
  logic          hit_raw, tag_bad, dat_bad, hit_ok, use_ix, cpu_bad;
  logic [31:0]   ln;
  logic [3:0]    lp, ln_par;
  always_comb begin
    ix      = i_rq.addr[IW:1];
    tg      = i_rq.addr[AW-1:IW+1];
    use_ix  = usable(ix, i_byp_lo, i_byp_hi);
    ln      = dat_q[ix];
    lp      = datp_q[ix];
    for (int k = 0; k < 4; k++) begin
      ln_par[k] = par8(ln[8*k +: 8]);
    end
    hit_raw = val_q[ix] && (tag_q[ix] == tg) && use_ix && !i_force_miss;
    tag_bad = val_q[ix] && use_ix && (tpar(tag_q[ix]) != tagp_q[ix]);
    dat_bad = (ln_par != lp);
    hit_ok  = hit_raw && !tag_bad && !dat_bad;
    cpu_bad = i_rq.we && ({par8(i_rq.wdata[15:8]), par8(i_rq.wdata[7:0])} != i_rq.wpar);
  end
  // memory read return check
  logic [3:0] mrd_par;
  logic       mrd_bad;
  logic [IW-1:0] rix;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      mrd_par[k] = par8(i_mem_rdata[8*k +: 8]);
    end
    mrd_bad = (mrd_par != i_mem_rpar);
    rix     = rq_q.addr[IW:1];
  end
  wire idle_take = (st_q == MPR_IDLE) && i_req;
  wire mem_done  = (st_q != MPR_IDLE) && i_mem_ack;
  wire rd_abort  = mem_done && (st_q == MPR_MRD) && (mrd_bad || i_mem_aerr);
  wire wr_abort  = mem_done && (st_q == MPR_MWR) && i_mem_aerr;
  wire hit_fail  = idle_take && !i_rq.we && hit_raw && !hit_ok;
  // sequence: hit answers next cycle, everything else goes to memory
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_q    <= MPR_IDLE;
    end else begin
      unique case (st_q)
        MPR_IDLE: begin
          if (i_req && i_rq.we) begin
            st_q <= MPR_MWR;
          end else if (i_req && !hit_ok) begin
            st_q    <= MPR_MRD;
          end
        end
        MPR_MRD, MPR_MWR: begin
          if (i_mem_ack) begin
            st_q    <= MPR_IDLE;
          end
        end
      endcase
    end
  end
  // captured request
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rq_q <= '0;
    end else if (idle_take) begin
      rq_q <= i_rq;
    end
  end
  // memory bus drive with address and control parity
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mreq_q   <= 1'b0;
      maddr_q  <= '0;
      mwe_q    <= 1'b0;
      mbe_q    <= 4'h0;
      mwdata_q <= 32'h0000_0000;
      mwpar_q  <= 4'h0;
      mapar_q  <= 1'b0;
    end else if (idle_take && !(hit_ok && !i_rq.we)) begin
      mreq_q   <= 1'b1;
      maddr_q  <= i_rq.addr[AW-1:1];
      mwe_q    <= i_rq.we;
      mbe_q    <= i_rq.addr[0] ? {i_rq.be, 2'b00} : {2'b00, i_rq.be};
      mwdata_q <= {i_rq.wdata, i_rq.wdata};
      mwpar_q  <= {i_rq.wpar, i_rq.wpar};
      mapar_q  <= ~(^{i_rq.addr[AW-1:1], i_rq.we});
    end else if (mem_done) begin
      mreq_q   <= 1'b0;
    end
  end
  // cache array: fill after memory read, merge on write hit
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      val_q <= '0;
    end else if (mem_done && st_q == MPR_MRD && usable(rix, i_byp_lo, i_byp_hi)) begin
      if (rd_abort) begin
        val_q[rix] <= 1'b0;
      end else begin
        val_q[rix]  <= 1'b1;
        tag_q[rix]  <= rq_q.addr[AW-1:IW+1];
        tagp_q[rix] <= tpar(rq_q.addr[AW-1:IW+1]);
        dat_q[rix]  <= i_mem_rdata;
        datp_q[rix] <= i_mem_rpar;
      end
    end else if (mem_done && st_q == MPR_MWR && !wr_abort && val_q[rix]
                 && tag_q[rix] == rq_q.addr[AW-1:IW+1]) begin
      for (int k = 0; k < 4; k++) begin
        if (mbe_q[k]) begin
          dat_q[rix][8*k +: 8] <= mwdata_q[8*k +: 8];
          datp_q[rix][k]       <= mwpar_q[k];
        end
      end
    end
  end
  // processor answer: generated byte parity on memory reads, stored line parity on hits
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ack_q   <= 1'b0;
      rdata_q <= 16'h0000;
      rpar_q  <= 2'h0;
    end else begin
      ack_q <= (idle_take && !i_rq.we && hit_ok) || (mem_done && !rd_abort && !wr_abort);
      if (idle_take && !i_rq.we && hit_ok) begin
        rdata_q <= i_rq.addr[0] ? ln[31:16] : ln[15:0];
        rpar_q  <= i_rq.addr[0] ? lp[3:2] : lp[1:0];
      end else if (mem_done && st_q == MPR_MRD) begin
        rdata_q <= rq_q.addr[0] ? i_mem_rdata[31:16] : i_mem_rdata[15:0];
        rpar_q  <= rq_q.addr[0] ? mrd_par[3:2] : mrd_par[1:0];
      end
    end
  end
  // abort now, or trap once the instruction has finished
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      abort_q     <= 1'b0;
      trap_q      <= 1'b0;
      trap_pend_q <= 1'b0;
      vec_q       <= `MPR_VEC_NONE;
    end else begin
      abort_q <= rd_abort || wr_abort;
      trap_q  <= trap_pend_q && i_instr_done;
      if ((idle_take && cpu_bad) || hit_fail) begin
        trap_pend_q <= 1'b1;
      end else if (i_instr_done) begin
        trap_pend_q <= 1'b0;
      end
      if (rd_abort || wr_abort || (trap_pend_q && i_instr_done)) begin
        vec_q <= `MPR_ERR_VECTOR;
      end
    end
  end
  // sticky error log; a new error wins over a clear in the same cycle
  mpr_err_s err_set;
  always_comb begin
    err_set.cpu_data   = idle_take && cpu_bad;
    err_set.cache_data = hit_fail && dat_bad;
    err_set.cache_tag  = hit_fail && tag_bad;
    err_set.mem_data   = mem_done && st_q == MPR_MRD && mrd_bad;
    err_set.mem_addr   = mem_done && i_mem_aerr;
  end
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      err_q <= `MPR_ERR_CLEAR;
    end else begin
      err_q <= (i_err_clr ? `MPR_ERR_CLEAR : err_q) | err_set;
    end
  end
  assign o_ack       = ack_q;
  assign o_rdata     = rdata_q;
  assign o_rpar      = rpar_q;
  assign o_abort     = abort_q;
  assign o_trap      = trap_q;
  assign o_vector    = vec_q;
  assign o_err       = err_q;
  assign o_mem_req   = mreq_q;
  assign o_mem_addr  = maddr_q;
  assign o_mem_we    = mwe_q;
  assign o_mem_be    = mbe_q;
  assign o_mem_wdata = mwdata_q;
  assign o_mem_wpar  = mwpar_q;
  assign o_mem_apar  = mapar_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_bad_hit;
    idle_take && !i_rq.we && hit_raw && !hit_ok;
  endsequence
  sequence s_retry;
    o_mem_req && !o_mem_we;
  endsequence

  chk_retry_issued: assert property (s_bad_hit |=> s_retry)
    else $error("bad cache hit did not retry from memory");
  chk_force_miss: assert property (idle_take && !i_rq.we && i_force_miss |=> st_q == MPR_MRD)
    else $error("forced miss answered from cache");
  chk_bypass_half: assert property (idle_take && !use_ix |-> !hit_ok)
    else $error("bypassed half produced a hit");
  chk_fill_line: assert property (mem_done && st_q == MPR_MRD && !rd_abort
      && usable(rix, i_byp_lo, i_byp_hi) |=> val_q[$past(rix)] && dat_q[$past(rix)] == $past(i_mem_rdata))
    else $error("retried data not written to cache");
  chk_abort_vec: assert property (rd_abort |=> o_abort && o_vector == `MPR_ERR_VECTOR && !o_ack)
    else $error("read parity error did not abort");
  chk_trap_late: assert property (s_bad_hit ##1 (!i_instr_done)[*3] ##1 i_instr_done |=> o_trap)
    else $error("trap not taken after instruction end");
  chk_err_sticky: assert property (err_set.mem_data |=> o_err.mem_data)
    else $error("memory parity error not logged");
  chk_rd_parity: assert property (o_ack |-> o_rpar == {par8(o_rdata[15:8]), par8(o_rdata[7:0])}
      || $past(st_q) == MPR_MWR || $past(hit_ok))
    else $error("processor read parity wrong");
  chk_addr_parity: assert property ($rose(o_mem_req) |-> o_mem_apar == ~(^{o_mem_addr, o_mem_we}))
    else $error("address parity wrong");
  chk_tag_pair: assert property (mem_done && st_q == MPR_MRD && !rd_abort
      && usable(rix, i_byp_lo, i_byp_hi) |=> tagp_q[$past(rix)] == tpar(tag_q[$past(rix)]))
    else $error("tag parity not stored");
endmodule

// >>> test/mpr_mem_model.sv
// main memory model: 64 two-word blocks, odd parity per byte
// assumes a level request from the cache, held until acknowledge
`timescale 1ns/1ns
module mpr_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_req,
  input  wire logic [19:0] i_addr,
  input  wire logic        i_we,
  input  wire logic [3:0]  i_be,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wpar,
  input  wire logic [1:0]  i_fault,  // 1 bad parity, 2 addr error, 3 fresh parity
  input  wire logic        i_slow,
  output logic             o_ack,
  output logic [31:0]      o_rdata,
  output logic [3:0]       o_rpar,
  output logic             o_aerr
);
  logic [35:0] mem [64];
  logic [1:0]  cnt_q;
  logic        busy_q;
  logic [5:0]  a;
  assign a = i_addr[5:0];
  // preload, one odd parity bit per stored byte
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i][31:0] = 32'h9e3779b9 * (i + 1);
      for (int k = 0; k < 4; k++) mem[i][32+k] = ~^mem[i][8*k+:8];
    end
  end
  // answer after 0 or 3 waits; idle lines toggle so stale data never passes
  always @(posedge i_clk) begin
    o_ack   <= 1'b0;
    o_aerr  <= 1'b0;
    o_rdata <= ~o_rdata;
    o_rpar  <= ~o_rpar;
    if (!i_req) busy_q <= 1'b0;
    if (!i_nrst) begin
      busy_q  <= 1'b0;
      cnt_q   <= 2'h0;
      o_rdata <= 32'h0;
      o_rpar  <= 4'h0;
    end else if (i_req && !busy_q) begin
      if (cnt_q == {2{i_slow}}) begin
        o_ack   <= 1'b1;
        busy_q  <= 1'b1;
        cnt_q   <= 2'h0;
        o_rdata <= mem[a][31:0];
        o_rpar  <= mem[a][35:32] ^ {3'h0, i_fault == 2'h1};
        o_aerr  <= i_fault == 2'h2;
        // byte writes keep the parity they came with, except under fault 3, which stores fresh parity
        for (int k = 0; k < 4; k++) begin
          if (i_we && i_be[k]) begin
            mem[a][8*k+:8] <= i_wdata[8*k+:8];
            mem[a][32+k]   <= (i_fault == 2'h3) ? ~^i_wdata[8*k+:8] : i_wpar[k];
          end
        end
      end else begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end
endmodule

// >>> test/tb_top.sv
// self-checking bench: random traffic plus parity fault cases
// assumes mpr_pkg compiled first and mpr_params.svh on the include path
`timescale 1ns/1ns
`include "mpr_params.svh"
module tb_top;
  import mpr_pkg::*;
  logic i_clk = 0, i_nrst = 0, byp_lo = 0, byp_hi = 0, fm = 0, req = 0;
  logic idone = 0, eclr = 0, slow = 0, used, ab, fin;
  logic ack, abort, trap, mreq, mwe, mapar, mack, maerr;
  logic [1:0] flt = 0, rpar;
  logic [15:0] rdata;
  logic [7:0] vec;
  logic [19:0] maddr;
  logic [3:0] mbe, mwpar, mrpar;
  logic [31:0] mwd, mrd;
  logic [31:0] sh [64];
  mpr_req_s rq = '0;
  mpr_err_s err;
  int fails = 0, checks = 0;

  always #5 i_clk = ~i_clk;

  mpr_cache u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_byp_lo(byp_lo), .i_byp_hi(byp_hi),
    .i_force_miss(fm), .i_req(req), .i_rq(rq), .o_ack(ack), .o_rdata(rdata), .o_rpar(rpar),
    .o_abort(abort), .o_trap(trap), .o_vector(vec), .i_instr_done(idone), .o_err(err),
    .i_err_clr(eclr), .o_mem_req(mreq), .o_mem_addr(maddr), .o_mem_we(mwe),
    .o_mem_be(mbe), .o_mem_wdata(mwd), .o_mem_wpar(mwpar), .o_mem_apar(mapar),
    .i_mem_ack(mack), .i_mem_rdata(mrd), .i_mem_rpar(mrpar), .i_mem_aerr(maerr));
  mpr_mem_model u_mem (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(mreq), .i_addr(maddr),
    .i_we(mwe), .i_be(mbe), .i_wdata(mwd), .i_wpar(mwpar), .i_fault(flt), .i_slow(slow),
    .o_ack(mack), .o_rdata(mrd), .o_rpar(mrpar), .o_aerr(maerr));

  function logic [1:0] op2(input logic [15:0] d);
    return {~^d[15:8], ~^d[7:0]};
  endfunction

  task chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask

  task results();
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one core access; notes memory use and abort, checks read data
  task acc(input logic we, input logic [5:0] b, input logic w, input logic [1:0] be,
           input logic [15:0] d, input logic [1:0] p);
    @(posedge i_clk);
    req <= 1'b1;
    rq  <= '{addr: {14'h0, b, w}, we: we, be: be, wdata: d, wpar: p};
    @(posedge i_clk);
    req <= 1'b0;
    used = 0;
    fin  = 0;
    repeat (40) if (!fin) begin
      #1;
      if (mreq === 1'b1) begin
        used = 1;
        chk(mapar === ~^{maddr, mwe}, "addr parity");
        chk(!mwe || mwpar === {p, p}, "write parity");
      end
      fin = ack | abort;
      if (!fin) @(posedge i_clk);
    end
    ab = abort;
    chk(fin, "no answer");
    if (ack && !we) chk(rdata === sh[b][w*16+:16] && rpar === op2(sh[b][w*16+:16]), "read");
    for (int k = 0; k < 2; k++) if (ack && we && be[k]) sh[b][w*16+8*k+:8] = d[8*k+:8];
  endtask

  // instruction end; the pending trap shows one cycle later
  task trap_chk();
    @(posedge i_clk) idone <= 1'b1;
    @(posedge i_clk) idone <= 1'b0;
    #1 chk(trap === 1'b1 && vec === `MPR_ERR_VECTOR, "trap");
  endtask

  // watchdog, far beyond the fewer than two thousand cycles the tests need
  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    logic [5:0] b;
    logic [15:0] d;
    logic w, we;
    for (int i = 0; i < 64; i++) sh[i] = 32'h9e3779b9 * (i + 1);
    void'($urandom(88636));
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1 chk(!ack && !mreq && !trap && vec === `MPR_VEC_NONE && err === '0, "reset");
    // random traffic, every fourth iteration with random bypass and force-miss settings
    for (int i = 0; i < 150; i++) begin
      b  = 6'($urandom);
      w  = 1'($urandom);
      d  = 16'($urandom);
      we = ($urandom % 3) == 0;
      @(posedge i_clk);
      {byp_lo, byp_hi, fm} <= (i % 4 == 0) ? 3'($urandom) : 3'h0;
      slow <= 1'($urandom);
      if (we) begin
        acc(1'b1, b, w, 2'($urandom % 3 + 1), d, op2(d));
        chk(used, "write kept");
      end else begin
        acc(1'b0, b, w, 2'h3, d, 2'h0);
        if (fm || (b[3] ? byp_hi : byp_lo)) chk(used, "no bypass");
        else begin
          acc(1'b0, b, w, 2'h3, d, 2'h0);
          chk(!used, "no hit");
        end
      end
    end
    // bad parity lands in a cached line only; memory stores fresh parity
    @(posedge i_clk) {byp_lo, byp_hi, fm, flt} <= 5'h03;
    slow <= 1'b0;
    acc(1'b0, 6'h05, 1'b0, 2'h3, 16'h0, 2'h0);
    acc(1'b1, 6'h05, 1'b0, 2'h3, 16'ha5c3, ~op2(16'ha5c3));
    chk(err.cpu_data === 1'b1, "core error");
    trap_chk();
    @(posedge i_clk) flt <= 2'h0;
    acc(1'b0, 6'h05, 1'b0, 2'h3, 16'h0, 2'h0);
    chk(used && err.cache_data === 1'b1, "no retry");
    trap_chk();
    acc(1'b0, 6'h05, 1'b0, 2'h3, 16'h0, 2'h0);
    chk(!used, "not repaired");
    // memory parity and address errors abort and drop the line
    for (int f = 1; f < 3; f++) begin
      @(posedge i_clk) eclr <= 1'b1;
      @(posedge i_clk) eclr <= 1'b0;
      {fm, flt} <= {1'b1, 2'(f)};
      #1 chk(err === '0, "clear");
      acc(1'b0, 6'h09, 1'b1, 2'h3, 16'h0, 2'h0);
      chk(ab && vec === `MPR_ERR_VECTOR, "no abort");
      chk((f == 1 ? err.mem_data : err.mem_addr) === 1'b1, "mem error");
      @(posedge i_clk) {fm, flt} <= 3'h0;
      acc(1'b0, 6'h09, 1'b1, 2'h3, 16'h0, 2'h0);
      chk(used && !ab, "line kept");
    end
    results();
  end
endmodule
